/* File: hw/cor_defines.svh */
// constants for the CAN option and receive block
// assumes a 32-bit bus, one register per aligned word
`ifndef COR_DEFINES_SVH
`define COR_DEFINES_SVH
// register indices; byte address is four times these
`define COR_IDX_FILT 8'h28
`define COR_IDX_DLCP 8'h29
`define COR_IDX_ECHK 8'h2A
`define COR_IDX_TDIV 8'h2B
`define COR_IDX_U1OP 8'h2C
`define COR_IDX_U1DV 8'h2D
`define COR_IDX_U2OP 8'h2E
`define COR_IDX_U2DV 8'h2F
`define COR_IDX_STAT 8'h30
`define COR_IDX_RATE 8'h31
`define COR_IDX_PROT 8'h32
// reset values
`define COR_RST_FILT 8'hFF
`define COR_RST_DLCP 8'hFF
`define COR_RST_ECHK 8'h3C
`define COR_RST_TDIV 8'h02
`define COR_RST_U1OP 8'hE0
`define COR_RST_U1DV 8'h04
`define COR_RST_U2OP 8'h80
`define COR_RST_U2DV 8'h0A
`define COR_RST_PROT 4'h6
// field positions
`define COR_B_M500 7
`define COR_B_M250 6
`define COR_B_QUIET 0
`define COR_B_TXID 7
`define COR_B_VDLC 6
`define COR_B_RXID 5
`define COR_B_MULT 4
`define COR_B_ISOLEN 7
`define COR_B_SRCH 4
// values
`define COR_DLC_ON 8'h00
`define COR_DIV_MIN 8'h01
`define COR_DIV_MAX 8'h40
`define COR_BASE_KBPS 9'd500
`define COR_CLK_MHZ 125
`define COR_CYC_500K 250
`endif

/* File: hw/cor_pkg.sv */
// types for the CAN option and receive block
// assumes cor_defines.svh alongside
package cor_pkg;
  typedef enum logic [4:0] {
    FS_IDLE = 5'h01, FS_HDR = 5'h02, FS_DLC = 5'h04,
    FS_DATA = 5'h08, FS_EOL = 5'h10
  } cor_fmt_t;
  typedef struct packed {
    logic ext;
    logic [28:0] id;
    logic [3:0] dlc;
    logic [63:0] data;
  } cor_frame_t;
endpackage : cor_pkg

/* File: hw/cor_can_rx.sv */
// CAN option registers, two-stage receive path, ascii formatter, tx buffer
// assumes an AHB-Lite master, a CAN controller giving whole frames
// and a serial sender draining tx_data by valid/ready
//
// Functional notes
// - search needs 500k/250k match per bits 7/6
// - quiet-bus send in search only if bit0
// - print length code when print default 00
// - error checks only for protocols 6..C
// - truck rate is 500 over its divisor
// - user one bit7 picks 11 or 29-bit
// - user one bit6 picks fixed or variable
// - user one bit5 accepts both id lengths
// - option bit4 speeds rate by 8/7
// - bits 2..0 select formatting mode
// - user one rate 500 over divisor
// - user two has own option byte
// - user two rate 500 over divisor
// - parameter values are plain hex bytes
// - bit 7 msb, bit 0 lsb
// - reported rate ignores the 8/7 factor
// - two staged receive registers
// - check, respond, format, ascii, buffer
// - free receive stages promptly, then queue
// - transmit buffer holds 512 bytes
// - full buffer flags and abandons frame
`timescale 1ns/1ps
`include "cor_defines.svh"
`default_nettype none
module cor_can_rx #(
  parameter int DEPTH = 512,
  parameter int AW = 9
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // frames from the can controller
  input wire logic frm_valid,
  input wire logic frm_ext,
  input wire logic [28:0] frm_id,
  input wire logic [3:0] frm_dlc,
  input wire logic [63:0] frm_data,
  input wire logic frm_err,
  // settings to the can controller
  output logic need_500_q,
  output logic need_250_q,
  output logic quiet_send_q,
  output logic tx_ext_q,
  output logic tx_var_dlc_q,
  output logic rx_any_id_q,
  output logic [2:0] fmt_mode_q,
  output logic [19:0] bit_period_q,
  output logic fc_req_q,
  // ascii towards the serial sender
  output logic tx_valid_q,
  output logic [7:0] tx_data_q,
  input wire logic tx_ready
);
  function automatic logic div_ok(input logic [7:0] v);
    div_ok = (v >= `COR_DIV_MIN) && (v <= `COR_DIV_MAX);
  endfunction : div_ok

  function automatic logic [7:0] hex_ch(input logic [3:0] n);
    hex_ch = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
  endfunction : hex_ch

  // parameter bytes, stored as given
  logic [7:0] filt_q, dlcp_q, echk_q, tdiv_q;
  logic [7:0] u1op_q, u1dv_q, u2op_q, u2dv_q;
  logic [3:0] prot_q;
  logic srch_q;
  logic ovf_q, ovr_q, err_q;

  // bus address phase capture
  logic wr_q;
  logic [7:0] widx_q;
  logic acc;
  logic [7:0] aidx;
  assign acc = hsel && htrans[1] && hready;
  assign aidx = haddr[9:2];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      widx_q <= 8'h00;
    end else begin
      wr_q <= acc && hwrite;
      widx_q <= aidx;
    end
  end

  logic [7:0] wb;
  assign wb = hwdata[7:0];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filt_q <= `COR_RST_FILT;
      dlcp_q <= `COR_RST_DLCP;
      echk_q <= `COR_RST_ECHK;
      tdiv_q <= `COR_RST_TDIV;
      u1op_q <= `COR_RST_U1OP;
      u1dv_q <= `COR_RST_U1DV;
      u2op_q <= `COR_RST_U2OP;
      u2dv_q <= `COR_RST_U2DV;
      prot_q <= `COR_RST_PROT;
      srch_q <= 1'b0;
    end else if (wr_q) begin
      case (widx_q)
        `COR_IDX_FILT: filt_q <= wb;
        `COR_IDX_DLCP: dlcp_q <= wb;
        `COR_IDX_ECHK: echk_q <= wb;
        `COR_IDX_TDIV: if (div_ok(wb)) tdiv_q <= wb;
        `COR_IDX_U1OP: u1op_q <= wb;
        `COR_IDX_U1DV: if (div_ok(wb)) u1dv_q <= wb;
        `COR_IDX_U2OP: u2op_q <= wb;
        `COR_IDX_U2DV: if (div_ok(wb)) u2dv_q <= wb;
        `COR_IDX_PROT: begin
          prot_q <= wb[3:0];
          srch_q <= wb[`COR_B_SRCH];
        end
        default: ;
      endcase
    end
  end

  // active profile decode; 6..9 are the fixed can protocols
  logic is_u1, is_u2, is_usr, is_can;
  logic [7:0] opt, div;
  logic a_ext, a_vdlc, a_any;
  logic [2:0] a_fmt;
  assign is_u1 = prot_q == 4'hB;
  assign is_u2 = prot_q == 4'hC;
  assign is_usr = is_u1 || is_u2;
  assign is_can = prot_q >= 4'h6 && prot_q <= 4'hC;
  assign opt = is_u1 ? u1op_q : u2op_q;

  always_comb begin
    div = (prot_q < 4'h8) ? 8'h01 : 8'h02;
    a_ext = prot_q[0];
    a_vdlc = 1'b0;
    a_any = 1'b0;
    a_fmt = 3'h1;
    if (prot_q == 4'hA) begin
      div = tdiv_q;
      a_ext = 1'b1;
      a_vdlc = 1'b1;
      a_fmt = 3'h2;
    end else if (is_usr) begin
      div = is_u1 ? u1dv_q : u2dv_q;
      a_ext = !opt[`COR_B_TXID];
      a_vdlc = opt[`COR_B_VDLC];
      a_any = opt[`COR_B_RXID];
      a_fmt = opt[2:0];
    end
  end

  // 500 kbps is 250 clocks; p8 holds the period in eighths of a clock
  logic [16:0] p8;
  logic [19:0] p_mul;
  logic mult;
  logic [8:0] kbps_q;
  assign p8 = 17'({9'h000, div} * 17'd2000);
  assign p_mul = 20'((21'(p8) * 21'd7) >> 6);
  assign mult = is_usr && opt[`COR_B_MULT];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      // search bit resets clear, so no match demands yet
      need_500_q <= 1'b0;
      need_250_q <= 1'b0;
      quiet_send_q <= 1'b0;
      tx_ext_q <= 1'b0;
      tx_var_dlc_q <= 1'b0;
      rx_any_id_q <= 1'b0;
      fmt_mode_q <= 3'h1;
      bit_period_q <= 20'd250;
      kbps_q <= 9'd500;
    end else begin
      need_500_q <= srch_q && filt_q[`COR_B_M500];
      need_250_q <= srch_q && filt_q[`COR_B_M250];
      quiet_send_q <= srch_q && filt_q[`COR_B_QUIET];
      tx_ext_q <= a_ext;
      tx_var_dlc_q <= a_vdlc;
      rx_any_id_q <= a_any;
      fmt_mode_q <= a_fmt;
      bit_period_q <= mult ? p_mul : 20'(p8 >> 3);
      kbps_q <= `COR_BASE_KBPS / {1'b0, div};
    end
  end

  // two receive stages
  cor_pkg::cor_frame_t s1_q, s2_q;
  logic s1v_q, s2v_q, take2, take_fmt;
  logic id_bad, len_bad, keep;
  assign id_bad = is_usr && !opt[`COR_B_RXID] && (frm_ext != a_ext);
  assign len_bad = is_can && echk_q[`COR_B_ISOLEN] && a_fmt == 3'h1
    && frm_dlc != 4'h8;
  assign keep = frm_valid && !frm_err && !id_bad && !len_bad;
  assign take2 = s1v_q && (!s2v_q || take_fmt);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1v_q <= 1'b0;
      s2v_q <= 1'b0;
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      if (keep) begin
        s1v_q <= 1'b1;
        s1_q <= '{frm_ext, frm_id, frm_dlc, frm_data};
      end else if (take2) begin
        s1v_q <= 1'b0;
      end
      if (take2) begin
        s2v_q <= 1'b1;
        s2_q <= s1_q;
      end else if (take_fmt) begin
        s2v_q <= 1'b0;
      end
    end
  end

  // formatter: id digits, optional length, data pairs, cr
  cor_pkg::cor_fmt_t st_q;
  cor_pkg::cor_frame_t f_q;
  logic [2:0] dig_q, byt_q;
  logic [1:0] ph_q;
  logic push, full;
  logic [7:0] ch;
  logic [3:0] nd, nb, last_b;
  logic [AW:0] cnt_q;
  assign full = cnt_q == (AW+1)'(DEPTH);
  assign take_fmt = st_q == cor_pkg::FS_IDLE && s2v_q;
  assign nd = f_q.ext ? 4'd8 : 4'd3;
  assign nb = (f_q.dlc > 4'h8) ? 4'h8 : f_q.dlc;
  assign last_b = nb - 4'h1;

  always_comb begin
    logic [31:0] idw;
    logic [7:0] b;
    idw = {3'h0, f_q.id} >> (5'(nd - 4'h1 - {1'b0, dig_q}) << 2);
    b = f_q.data[63 - {byt_q, 3'h0} -: 8];
    ch = 8'h0D;
    unique case (st_q)
      cor_pkg::FS_HDR: ch = hex_ch(idw[3:0]);
      cor_pkg::FS_DLC: ch = ph_q[0] ? 8'h20 : hex_ch(f_q.dlc);
      cor_pkg::FS_DATA: ch = (ph_q == 2'd0) ? hex_ch(b[7:4])
        : (ph_q == 2'd1) ? hex_ch(b[3:0]) : 8'h20;
      default: ch = 8'h0D;
    endcase
  end
  assign push = st_q != cor_pkg::FS_IDLE && !full;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= cor_pkg::FS_IDLE;
      f_q <= '0;
      dig_q <= 3'h0;
      byt_q <= 3'h0;
      ph_q <= 2'h0;
    end else if (st_q != cor_pkg::FS_IDLE && full) begin
      st_q <= cor_pkg::FS_IDLE;
    end else begin
      unique case (st_q)
        cor_pkg::FS_IDLE: if (s2v_q) begin
          f_q <= s2_q;
          dig_q <= 3'h0;
          st_q <= cor_pkg::FS_HDR;
        end
        cor_pkg::FS_HDR: begin
          dig_q <= dig_q + 3'h1;
          ph_q <= 2'h0;
          byt_q <= 3'h0;
          if ({1'b0, dig_q} == nd - 4'h1) begin
            if (dlcp_q == `COR_DLC_ON) st_q <= cor_pkg::FS_DLC;
            else if (nb == 4'h0) st_q <= cor_pkg::FS_EOL;
            else st_q <= cor_pkg::FS_DATA;
          end
        end
        cor_pkg::FS_DLC: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q[0]) begin
            ph_q <= 2'h0;
            st_q <= (nb == 4'h0) ? cor_pkg::FS_EOL : cor_pkg::FS_DATA;
          end
        end
        cor_pkg::FS_DATA: begin
          ph_q <= ph_q + 2'h1;
          if (ph_q == 2'd2) begin
            ph_q <= 2'h0;
            byt_q <= byt_q + 3'h1;
            if ({1'b0, byt_q} == last_b) st_q <= cor_pkg::FS_EOL;
          end
        end
        cor_pkg::FS_EOL: st_q <= cor_pkg::FS_IDLE;
        default: st_q <= cor_pkg::FS_IDLE;
      endcase
    end
  end

  // flow control request on an iso first frame
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) fc_req_q <= 1'b0;
    else fc_req_q <= take_fmt && fmt_mode_q == 3'h1
      && s2_q.data[63:60] == 4'h1;
  end

  // transmit buffer; output stage is a separate flop
  logic [7:0] mem [DEPTH];
  logic [AW-1:0] wp_q, rp_q;
  logic pop;
  assign pop = cnt_q != '0 && (!tx_valid_q || tx_ready);

  always_ff @(posedge hclk) begin
    if (push) mem[wp_q] <= ch;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wp_q <= '0;
      rp_q <= '0;
      cnt_q <= '0;
      tx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
    end else begin
      if (push) wp_q <= wp_q + 1'b1;
      if (pop) rp_q <= rp_q + 1'b1;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
        tx_valid_q <= 1'b1;
        tx_data_q <= mem[rp_q];
      end else if (tx_ready) begin
        tx_valid_q <= 1'b0;
      end
    end
  end

  // sticky status, write one to clear, set wins
  logic [2:0] clr;
  assign clr = (wr_q && widx_q == `COR_IDX_STAT) ? wb[2:0] : 3'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_q <= 1'b0;
      ovr_q <= 1'b0;
      err_q <= 1'b0;
    end else begin
      ovf_q <= (st_q != cor_pkg::FS_IDLE && full) || (ovf_q && !clr[0]);
      ovr_q <= (keep && s1v_q && !take2) || (ovr_q && !clr[1]);
      err_q <= (frm_valid && (frm_err || len_bad))
        || (err_q && !clr[2]);
    end
  end

  // read data registered in address phase; zero-wait, always okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      if (acc && !hwrite) begin
        unique case (aidx)
          `COR_IDX_FILT: hrdata <= {24'h0, filt_q};
          `COR_IDX_DLCP: hrdata <= {24'h0, dlcp_q};
          `COR_IDX_ECHK: hrdata <= {24'h0, echk_q};
          `COR_IDX_TDIV: hrdata <= {24'h0, tdiv_q};
          `COR_IDX_U1OP: hrdata <= {24'h0, u1op_q};
          `COR_IDX_U1DV: hrdata <= {24'h0, u1dv_q};
          `COR_IDX_U2OP: hrdata <= {24'h0, u2op_q};
          `COR_IDX_U2DV: hrdata <= {24'h0, u2dv_q};
          `COR_IDX_STAT: hrdata <= {16'h0, 6'(cnt_q), 5'h0,
            s2v_q, s1v_q, err_q, ovr_q, ovf_q};
          `COR_IDX_RATE: hrdata <= {3'h0, bit_period_q, kbps_q};
          `COR_IDX_PROT: hrdata <= {27'h0, srch_q, prot_q};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  sequence s_frame_in;
    keep && !s1v_q && !s2v_q;
  endsequence
  sequence s_staged;
    ##1 s1v_q ##1 s2v_q;
  endsequence

  a_bus_okay: assert property (@(posedge hclk) disable iff (!hresetn)
    hreadyout && !hresp) else $error("bus not ready/okay");
  a_filter_bits: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 need_500_q == $past(srch_q && filt_q[7]))
    else $error("500k match wrong");
  a_quiet_send: assert property (
    @(posedge hclk) disable iff (!hresetn)
    !srch_q |=> !quiet_send_q)
    else $error("quiet send outside search");
  a_dlc_print: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_q == cor_pkg::FS_DLC |-> dlcp_q == 8'h00)
    else $error("length printed while off");
  a_div_range: assert property (
    @(posedge hclk) disable iff (!hresetn)
    u1dv_q >= 8'h01 && u1dv_q <= 8'h40 && u2dv_q <= 8'h40
    && tdiv_q <= 8'h40)
    else $error("divisor out of range");
  // floor of 500 over the divisor, never the scaled rate
  a_rate_base: assert property (
    @(posedge hclk) disable iff (!hresetn)
    ##1 16'(kbps_q) * 16'($past(div)) <= 16'd500
    && (16'(kbps_q) + 16'd1) * 16'($past(div)) > 16'd500)
    else $error("reported rate not base");
  // 250 clocks a bit per divisor step, times 7/8, truncated
  a_mult_rate: assert property (
    @(posedge hclk) disable iff (!hresetn)
    mult |=> bit_period_q == 20'((20'($past(div)) * 20'd1750) >> 3))
    else $error("8/7 scaling missing");
  a_two_stage: assert property (
    @(posedge hclk) disable iff (!hresetn)
    s_frame_in |-> s_staged)
    else $error("frame not staged");
  a_buf_depth: assert property (
    @(posedge hclk) disable iff (!hresetn)
    cnt_q <= (AW+1)'(DEPTH))
    else $error("buffer over depth");
  a_full_abandon: assert property (
    @(posedge hclk) disable iff (!hresetn)
    st_q != cor_pkg::FS_IDLE && full |=> ovf_q && st_q == cor_pkg::FS_IDLE)
    else $error("full not abandoned");
endmodule : cor_can_rx
`default_nettype wire

/* File: testbench/cor_can_node.sv */
// CAN node model sending whole frames, plus the serial host draining bytes
// assumes the bench drives it through send/idle and the stall/slow flags
`timescale 1ns/1ps
`default_nettype none
module cor_can_node (
  // clock
  input wire logic hclk,
  // frames towards the block
  output logic frm_valid,
  output logic frm_ext,
  output logic [28:0] frm_id,
  output logic [3:0] frm_dlc,
  output logic [63:0] frm_data,
  output logic frm_err,
  // serial side
  input wire logic tx_valid_q,
  input wire logic [7:0] tx_data_q,
  output logic tx_ready,
  input wire logic fc_req_q
);
  logic stall = 1'b0;
  logic slow = 1'b0;
  int fc_n = 0;
  logic [7:0] rx_q[$];
  initial begin
    {frm_valid, frm_ext, frm_id, frm_dlc, frm_data, frm_err} = '0;
    tx_ready = 1'b1;
  end
  // host takes bytes unless stalled; slow mode answers every other cycle
  always @(posedge hclk) begin
    if (tx_valid_q && tx_ready) rx_q.push_back(tx_data_q);
    if (fc_req_q) fc_n++;
    tx_ready <= !stall && !(slow && tx_ready);
  end
  task automatic send(input logic e, input logic [28:0] id,
                      input logic [3:0] n, input logic [63:0] d,
                      input logic err);
    @(posedge hclk);
    frm_valid <= 1'b1;
    frm_ext <= e;
    frm_id <= id;
    frm_dlc <= n;
    frm_data <= d;
    frm_err <= err;
  endtask : send
  // released fields show inverted junk, never the last frame
  task automatic idle();
    @(posedge hclk);
    frm_valid <= 1'b0;
    {frm_ext, frm_id, frm_dlc, frm_data} <=
      ~{frm_ext, frm_id, frm_dlc, frm_data};
  endtask : idle
endmodule : cor_can_node
`default_nettype wire

/* File: testbench/test_cor_can_rx.sv */
// self-checking bench for the CAN option and receive block
// assumes cor_defines.svh on the include path and the node model
`timescale 1ns/1ps
`include "cor_defines.svh"
`default_nettype none
module test_cor_can_rx;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, fc_req_q, tx_valid_q, tx_ready;
  logic need_500_q, need_250_q, quiet_send_q;
  logic tx_ext_q, tx_var_dlc_q, rx_any_id_q;
  logic [2:0] fmt_mode_q;
  logic [19:0] bit_period_q;
  logic [7:0] tx_data_q;
  logic frm_valid, frm_ext, frm_err;
  logic [28:0] frm_id;
  logic [3:0] frm_dlc;
  logic [63:0] frm_data;
  int mismatches = 0;
  int checked = 0;
  logic [7:0] exp_q[$];
  logic [7:0] rst_v [8] = '{`COR_RST_FILT, `COR_RST_DLCP, `COR_RST_ECHK,
    `COR_RST_TDIV, `COR_RST_U1OP, `COR_RST_U1DV, `COR_RST_U2OP, `COR_RST_U2DV};
  localparam logic [63:0] D1 = 64'h0241_0C1A_2B3C_4D5E;
  localparam logic [63:0] D2 = 64'h1014_4902_0157_4442;

  cor_can_rx DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .frm_valid(frm_valid), .frm_ext(frm_ext), .frm_id(frm_id),
    .frm_dlc(frm_dlc), .frm_data(frm_data), .frm_err(frm_err),
    .need_500_q(need_500_q), .need_250_q(need_250_q),
    .quiet_send_q(quiet_send_q), .tx_ext_q(tx_ext_q),
    .tx_var_dlc_q(tx_var_dlc_q), .rx_any_id_q(rx_any_id_q),
    .fmt_mode_q(fmt_mode_q), .bit_period_q(bit_period_q),
    .fc_req_q(fc_req_q), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
    .tx_ready(tx_ready));
  cor_can_node node (.hclk(hclk), .frm_valid(frm_valid), .frm_ext(frm_ext),
    .frm_id(frm_id), .frm_dlc(frm_dlc), .frm_data(frm_data),
    .frm_err(frm_err), .tx_valid_q(tx_valid_q), .tx_data_q(tx_data_q),
    .tx_ready(tx_ready), .fc_req_q(fc_req_q));

  always #4 hclk = ~hclk;

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic close_out();
    $display("mismatches %0d checked %0d", mismatches, checked);
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : close_out

  // single word transfer; read data lands in rd
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  function automatic logic [7:0] hx(input logic [3:0] v);
    return (v < 4'hA) ? 8'h30 + 8'(v) : 8'h37 + 8'(v);
  endfunction : hx

  task automatic exp_frame(input logic [11:0] id, input logic [63:0] d,
                           input logic dlcp);
    for (int i = 2; i >= 0; i--) exp_q.push_back(hx(id[i*4 +: 4]));
    if (dlcp) exp_q.push_back(8'h38);
    if (dlcp) exp_q.push_back(8'h20);
    for (int i = 7; i >= 0; i--) begin
      exp_q.push_back(hx(d[i*8+4 +: 4]));
      exp_q.push_back(hx(d[i*8 +: 4]));
      exp_q.push_back(8'h20);
    end
    exp_q.push_back(8'h0D);
  endtask : exp_frame

  // settle for a frame's formatting time, then compare the stream
  task automatic cmp_out();
    int n;
    n = 0;
    repeat (60) @(posedge hclk);
    while (node.rx_q.size() < exp_q.size() && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    chk(node.rx_q.size(), exp_q.size());
    foreach (exp_q[i]) begin
      if (i < node.rx_q.size()) chk(node.rx_q[i], exp_q[i]);
    end
    exp_q.delete();
    node.rx_q.delete();
  endtask : cmp_out

  initial begin
    repeat (50000) @(posedge hclk);
    mismatches++;
    close_out();
  end

  initial begin
    int n;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    for (int i = 0; i < 8; i++) begin
      bus(0, 32'hA0 + 32'(4 * i), 0);
      chk(rd, 32'(rst_v[i]));
    end
    bus(0, 32'hD0, 0);
    chk(rd, 0);
    // search filter, reserved bits kept at one
    bus(1, 32'hC8, 32'h16);
    bus(1, 32'hA0, 32'hBE);
    bus(0, 32'hA0, 0);
    chk({need_500_q, need_250_q, quiet_send_q}, 3'b100);
    bus(1, 32'hA0, 32'h7F);
    bus(0, 32'hA0, 0);
    chk({need_500_q, need_250_q, quiet_send_q}, 3'b011);
    // first user profile: format codes 0 to 2, then the 8/7 factor
    bus(1, 32'hC8, 32'h0B);
    bus(1, 32'hB4, 32'h0A);
    for (int f = 0; f < 3; f++) begin
      bus(1, 32'hB0, 32'(f));
      bus(0, 32'hC4, 0);
      chk(rd, {3'b0, 20'd2500, 9'd50});
      chk({tx_ext_q, tx_var_dlc_q, rx_any_id_q, fmt_mode_q},
        32'h20 | f);
    end
    bus(1, 32'hB0, 32'hF0);
    bus(0, 32'hC4, 0);
    chk(rd, {3'b0, 20'd2187, 9'd50});
    chk(bit_period_q, 20'd2187);
    chk({tx_ext_q, tx_var_dlc_q, rx_any_id_q}, 3'b011);
    // out-of-range divisors leave the old value
    bus(1, 32'hB4, 32'h41);
    bus(1, 32'hB4, 32'h00);
    bus(0, 32'hB4, 0);
    chk(rd, 32'h0A);
    bus(1, 32'hB4, 32'h40);
    bus(0, 32'hB4, 0);
    chk(rd, 32'h40);
    // second user profile and truck profile
    bus(1, 32'hB8, 32'h00);
    bus(1, 32'hBC, 32'h05);
    bus(1, 32'hC8, 32'h0C);
    bus(0, 32'hC4, 0);
    chk(rd, {3'b0, 20'd1250, 9'd100});
    chk(tx_ext_q, 1'b1);
    bus(1, 32'hAC, 32'h19);
    bus(1, 32'hC8, 32'h0A);
    bus(0, 32'hC4, 0);
    chk(rd, {3'b0, 20'd6250, 9'd20});
    // frames with a slow host, then back to back with length code
    bus(1, 32'hC8, 32'h06);
    node.slow <= 1'b1;
    node.send(0, 29'h7E8, 4'h8, D1, 0);
    node.idle();
    exp_frame(12'h7E8, D1, 0);
    cmp_out();
    bus(1, 32'hA4, 32'h00);
    node.send(0, 29'h7E9, 4'h8, D1, 0);
    node.send(0, 29'h7EA, 4'h8, D2, 0);
    node.idle();
    exp_frame(12'h7E9, D1, 1);
    exp_frame(12'h7EA, D2, 1);
    cmp_out();
    chk(node.fc_n, 1);
    bus(1, 32'hA4, 32'hFF);
    // short frame under the length check, then a faulty frame
    bus(1, 32'hA8, 32'hBC);
    node.send(0, 29'h7E8, 4'h4, D1, 0);
    node.send(0, 29'h7E8, 4'h8, D1, 1);
    node.idle();
    cmp_out();
    bus(0, 32'hC0, 0);
    chk(rd[2], 1'b1);
    // stalled host until the buffer overflows
    bus(1, 32'hC0, 32'h07);
    node.slow <= 1'b0;
    node.stall <= 1'b1;
    for (int k = 0; k < 20; k++) begin
      node.send(0, 29'h123, 4'h8, D1, 0);
      node.idle();
      repeat (40) @(posedge hclk);
    end
    bus(0, 32'hC0, 0);
    chk(rd[0], 1'b1);
    bus(1, 32'hC0, 32'h01);
    bus(0, 32'hC0, 0);
    chk(rd[0], 1'b0);
    node.stall <= 1'b0;
    n = 0;
    repeat (2) @(posedge hclk);
    while (tx_valid_q !== 1'b0 && n < 3000) begin
      @(posedge hclk);
      n++;
    end
    // 512 held in the buffer plus the byte parked in the output flop
    chk(node.rx_q.size(), 32'd513);
    close_out();
  end
endmodule : test_cor_can_rx
`default_nettype wire
